// ===== common/irq_dispatch_pkg.sv
// Function
// - Fixed vector per source, 8 bytes apart
// - Same level: lowest fixed order wins
// - Vectoring clears external 0/1, timer 0/1 flags
// - Global gate zero blocks every source
// - Main enable bits map per source
// - Enable register at 0xA8, bit-addressable, resets zero
// - Timer 2 requests on either overflow flag
// - Serial port 0 any of four flags
// - UART requests on receive or transmit flag
// - External lines need enable and pending flag
// - Supply warning uses read-only flags, vector 0x007B
// - Conversion done: 0x0053, order 10, extended bit 3
// - High never preempted; low preempted by high
// - Disabled requests stay pending until gate returns
// - Requests sampled and decoded every cycle
// - Flag still set after return re-requests immediately
`default_nettype none
package irq_dispatch_pkg;

  localparam int unsigned NUM_SRC = 19;
  localparam int unsigned IDX_W   = 5;

  // Register addresses
  localparam logic [7:0] MASK_ADDR     = 8'hA8;
  localparam logic [7:0] BASE_PRI_ADDR = 8'hB8;
  localparam logic [7:0] EXT_EN1_ADDR  = 8'hE6;
  localparam logic [7:0] EXT_EN2_ADDR  = 8'hE7;
  localparam logic [7:0] EXT_PRI1_ADDR = 8'hF6;
  localparam logic [7:0] EXT_PRI2_ADDR = 8'hF7;

  // Reset values and fixed read bits
  localparam logic [7:0] MASK_RESET     = 8'h00;
  localparam logic [7:0] BASE_PRI_RESET = 8'h00;
  localparam logic [7:0] EXT_RESET      = 8'h00;
  localparam logic [7:0] PRI_READ_ONES  = 8'h80;

  // Field positions
  localparam int unsigned GLOBAL_BIT    = 7;
  localparam int unsigned MASK_SRC_W    = 7;
  localparam int unsigned EXT_EN2_SRC_W = 4;

  // Fixed order of sources
  localparam logic [IDX_W-1:0] SRC_EXT0   = 5'h00;
  localparam logic [IDX_W-1:0] SRC_T0     = 5'h01;
  localparam logic [IDX_W-1:0] SRC_EXT1   = 5'h02;
  localparam logic [IDX_W-1:0] SRC_T1     = 5'h03;
  localparam logic [IDX_W-1:0] SRC_UART   = 5'h04;
  localparam logic [IDX_W-1:0] SRC_T2     = 5'h05;
  localparam logic [IDX_W-1:0] SRC_SPI0   = 5'h06;
  localparam logic [IDX_W-1:0] SRC_TWI    = 5'h07;
  localparam logic [IDX_W-1:0] SRC_RTC    = 5'h08;
  localparam logic [IDX_W-1:0] SRC_ADCWIN = 5'h09;
  localparam logic [IDX_W-1:0] SRC_ADC    = 5'h0A;
  localparam logic [IDX_W-1:0] SRC_PCA    = 5'h0B;
  localparam logic [IDX_W-1:0] SRC_CMP0   = 5'h0C;
  localparam logic [IDX_W-1:0] SRC_CMP1   = 5'h0D;
  localparam logic [IDX_W-1:0] SRC_T3     = 5'h0E;
  localparam logic [IDX_W-1:0] SRC_SUPPLY = 5'h0F;
  localparam logic [IDX_W-1:0] SRC_PMATCH = 5'h10;
  localparam logic [IDX_W-1:0] SRC_OSCF   = 5'h11;
  localparam logic [IDX_W-1:0] SRC_SPI1   = 5'h12;
  localparam logic [IDX_W-1:0] HW_CLR_N   = 5'h04;

  // Vector addresses
  localparam logic [15:0] RESET_VEC  = 16'h0000;
  localparam logic [15:0] VEC_BASE   = 16'h0003;
  localparam logic [15:0] VEC_SUPPLY = 16'h007B;
  localparam logic [15:0] VEC_ADC    = 16'h0053;

endpackage : irq_dispatch_pkg
`default_nettype wire

// ===== design/irq_arbiter.sv
`default_nettype none
module irq_arbiter #(
  parameter int unsigned N = 19,
  parameter int unsigned W = 5
) (
  // Sources
  input  wire logic [N-1:0] pend_i,
  input  wire logic [N-1:0] en_i,
  input  wire logic [N-1:0] pri_i,
  input  wire logic         global_i,
  // Service state
  input  wire logic         insvc_low_i,
  input  wire logic         insvc_high_i,
  // Decision
  output logic              req_o,
  output logic [W-1:0]      idx_o,
  output logic              level_o,
  output logic              hi_cand_o
);

  logic [N-1:0] cand;
  logic [N-1:0] hi;
  logic [N-1:0] pick;

  for (genvar g = 0; g < N; g++) begin : g_gate
    assign cand[g] = pend_i[g] & en_i[g] & global_i;
    assign hi[g]   = cand[g] & pri_i[g];
  end

  assign hi_cand_o = |hi;

  always_comb begin
    idx_o   = '0;
    level_o = 1'b0;
    req_o   = 1'b0;
    pick    = (|hi) ? hi : cand;
    if (!insvc_high_i && (!insvc_low_i || (|hi))) begin
      req_o   = |pick;
      level_o = |hi;
    end
    for (int i = N - 1; i >= 0; i--) begin
      if (pick[i]) begin
        idx_o = W'(i);
      end
    end
  end

endmodule : irq_arbiter
`default_nettype wire

// ===== design/irq_sfr_regs.sv
`default_nettype none
module irq_sfr_regs (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // Special-function register access
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_bit_wr_i,
  input  wire logic       sfr_bit_val_i,
  input  wire logic       sfr_rd_i,
  output logic [7:0]      rdata_o,
  output logic            hit_o,
  // Register contents
  output logic [7:0]      mask_o,
  output logic [7:0]      base_pri_o,
  output logic [7:0]      ext_en1_o,
  output logic [7:0]      ext_en2_o,
  output logic [7:0]      ext_pri1_o,
  output logic [7:0]      ext_pri2_o
);

  typedef struct packed {
    logic [7:0] mask;
    logic [7:0] base_pri;
    logic [7:0] ext_en1;
    logic [7:0] ext_en2;
    logic [7:0] ext_pri1;
    logic [7:0] ext_pri2;
    logic [7:0] rdata;
    logic       hit;
  } regs_s;

  regs_s st_r;
  regs_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (sfr_wr_i) begin
      if (sfr_addr_i == irq_dispatch_pkg::MASK_ADDR) begin
        st_nxt.mask = sfr_wdata_i;
      end else if (sfr_addr_i == irq_dispatch_pkg::BASE_PRI_ADDR) begin
        st_nxt.base_pri = sfr_wdata_i & ~irq_dispatch_pkg::PRI_READ_ONES;
      end else if (sfr_addr_i == irq_dispatch_pkg::EXT_EN1_ADDR) begin
        st_nxt.ext_en1 = sfr_wdata_i;
      end else if (sfr_addr_i == irq_dispatch_pkg::EXT_EN2_ADDR) begin
        st_nxt.ext_en2 = sfr_wdata_i;
      end else if (sfr_addr_i == irq_dispatch_pkg::EXT_PRI1_ADDR) begin
        st_nxt.ext_pri1 = sfr_wdata_i;
      end else if (sfr_addr_i == irq_dispatch_pkg::EXT_PRI2_ADDR) begin
        st_nxt.ext_pri2 = sfr_wdata_i;
      end
    end
    // bit writes into the bit-addressable pair
    if (sfr_bit_wr_i) begin
      if (sfr_addr_i[7:3] == irq_dispatch_pkg::MASK_ADDR[7:3]) begin
        st_nxt.mask[sfr_addr_i[2:0]] = sfr_bit_val_i;
      end else if (sfr_addr_i[7:3] == irq_dispatch_pkg::BASE_PRI_ADDR[7:3]
                   && sfr_addr_i[2:0] != 3'h7) begin
        st_nxt.base_pri[sfr_addr_i[2:0]] = sfr_bit_val_i;
      end
    end
    if (sfr_rd_i) begin
      st_nxt.hit = 1'b1;
      if (sfr_addr_i == irq_dispatch_pkg::MASK_ADDR) begin
        st_nxt.rdata = st_r.mask;
      end else if (sfr_addr_i == irq_dispatch_pkg::BASE_PRI_ADDR) begin
        st_nxt.rdata = st_r.base_pri | irq_dispatch_pkg::PRI_READ_ONES;
      end else if (sfr_addr_i == irq_dispatch_pkg::EXT_EN1_ADDR) begin
        st_nxt.rdata = st_r.ext_en1;
      end else if (sfr_addr_i == irq_dispatch_pkg::EXT_EN2_ADDR) begin
        st_nxt.rdata = st_r.ext_en2;
      end else if (sfr_addr_i == irq_dispatch_pkg::EXT_PRI1_ADDR) begin
        st_nxt.rdata = st_r.ext_pri1;
      end else if (sfr_addr_i == irq_dispatch_pkg::EXT_PRI2_ADDR) begin
        st_nxt.rdata = st_r.ext_pri2;
      end else begin
        st_nxt.rdata = 8'h00;
        st_nxt.hit   = 1'b0;
      end
    end
    if (srst_i) begin
      st_nxt          = '0;
      st_nxt.mask     = irq_dispatch_pkg::MASK_RESET;
      st_nxt.base_pri = irq_dispatch_pkg::BASE_PRI_RESET;
      st_nxt.ext_en1  = irq_dispatch_pkg::EXT_RESET;
      st_nxt.ext_en2  = irq_dispatch_pkg::EXT_RESET;
      st_nxt.ext_pri1 = irq_dispatch_pkg::EXT_RESET;
      st_nxt.ext_pri2 = irq_dispatch_pkg::EXT_RESET;
    end
  end

  always_ff @(posedge mclk_i) begin
    st_r <= st_nxt;
  end

  assign rdata_o = st_r.rdata;
  assign hit_o   = st_r.hit;
  assign mask_o     = st_r.mask;
  assign base_pri_o = st_r.base_pri;
  assign ext_en1_o  = st_r.ext_en1;
  assign ext_en2_o  = st_r.ext_en2;
  assign ext_pri1_o = st_r.ext_pri1;
  assign ext_pri2_o = st_r.ext_pri2;

  AST_MASK_RESET_ZERO: assert property (@(posedge mclk_i) srst_i |=> st_r.mask == 8'h00)
    else $error("enable register not zero after reset");

  AST_MASK_BIT_WRITE: assert property (@(posedge mclk_i) disable iff (srst_i)
    (sfr_bit_wr_i && !sfr_wr_i && sfr_addr_i[7:3] == 5'h15)
    |=> st_r.mask[$past(sfr_addr_i[2:0])] == $past(sfr_bit_val_i))
    else $error("enable register bit write lost");

endmodule : irq_sfr_regs
`default_nettype wire

// ===== design/irq_enable_priority_dispatch.sv
`default_nettype none
module irq_enable_priority_dispatch (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       srst_i,
  // Special-function register access
  input  wire logic [7:0] sfr_addr_i,
  input  wire logic [7:0] sfr_wdata_i,
  input  wire logic       sfr_wr_i,
  input  wire logic       sfr_bit_wr_i,
  input  wire logic       sfr_bit_val_i,
  input  wire logic       sfr_rd_i,
  output logic [7:0]      sfr_rdata_o,
  output logic            sfr_hit_o,
  // Base sources
  input  wire logic       ext_line0_pending_i,
  input  wire logic       timer0_overflow_flag_i,
  input  wire logic       ext_line1_pending_i,
  input  wire logic       timer1_overflow_flag_i,
  input  wire logic       uart_rx_complete_i,
  input  wire logic       uart_tx_complete_i,
  input  wire logic       timer2_high_overflow_i,
  input  wire logic       timer2_low_overflow_i,
  input  wire logic       serial_port_transfer_done_i,
  input  wire logic       write_collision_i,
  input  wire logic       mode_fault_i,
  input  wire logic       receive_overrun_i,
  // Extended sources
  input  wire logic       two_wire_flag_i,
  input  wire logic       rtc_alarm_flag_i,
  input  wire logic       adc_window_flag_i,
  input  wire logic       conversion_done_flag_i,
  input  wire logic       counter_array_flag_i,
  input  wire logic [1:0] comparator0_flags_i,
  input  wire logic [1:0] comparator1_flags_i,
  input  wire logic [1:0] timer3_flags_i,
  input  wire logic       supply_good_flag_i,
  input  wire logic       battery_good_flag_i,
  input  wire logic       port_match_i,
  input  wire logic       osc_fail_flag_i,
  input  wire logic [3:0] serial_port1_flags_i,
  // Core handshake
  input  wire logic       cpu_ack_i,
  input  wire logic       cpu_reti_i,
  output logic            irq_req_o,
  output logic [15:0]     irq_vector_o,
  output logic            irq_level_o,
  output logic [3:0]      hw_clear_o,
  output logic [1:0]      in_service_o
);

  localparam int unsigned N = irq_dispatch_pkg::NUM_SRC;
  localparam int unsigned W = irq_dispatch_pkg::IDX_W;

  typedef struct packed {
    logic          req;
    logic [15:0]   vec;
    logic          level;
    logic [W-1:0]  idx;
    logic [3:0]    clr;
    logic          insvc_low;
    logic          insvc_high;
  } disp_s;

  disp_s        st_r;
  disp_s        st_nxt;

  logic [7:0]   enable_mask;
  logic [7:0]   base_pri;
  logic [7:0]   ext_en1;
  logic [7:0]   ext_en2;
  logic [7:0]   ext_pri1;
  logic [7:0]   ext_pri2;
  logic [N-1:0] src_pend;
  logic [N-1:0] src_en;
  logic [N-1:0] src_pri;
  logic         global_irq_gate;
  logic         arb_req;
  logic [W-1:0] arb_idx;
  logic         arb_level;
  logic         arb_hi;
  logic         take;

  irq_sfr_regs u_regs (
    .mclk_i        (mclk_i),
    .srst_i        (srst_i),
    .sfr_addr_i    (sfr_addr_i),
    .sfr_wdata_i   (sfr_wdata_i),
    .sfr_wr_i      (sfr_wr_i),
    .sfr_bit_wr_i  (sfr_bit_wr_i),
    .sfr_bit_val_i (sfr_bit_val_i),
    .sfr_rd_i      (sfr_rd_i),
    .rdata_o       (sfr_rdata_o),
    .hit_o         (sfr_hit_o),
    .mask_o        (enable_mask),
    .base_pri_o    (base_pri),
    .ext_en1_o     (ext_en1),
    .ext_en2_o     (ext_en2),
    .ext_pri1_o    (ext_pri1),
    .ext_pri2_o    (ext_pri2)
  );

  assign global_irq_gate = enable_mask[irq_dispatch_pkg::GLOBAL_BIT];

  assign src_en  = {ext_en2[irq_dispatch_pkg::EXT_EN2_SRC_W-1:0], ext_en1,
                    enable_mask[irq_dispatch_pkg::MASK_SRC_W-1:0]};
  assign src_pri = {ext_pri2[irq_dispatch_pkg::EXT_EN2_SRC_W-1:0], ext_pri1,
                    base_pri[irq_dispatch_pkg::MASK_SRC_W-1:0]};

  // external lines from their latched flags
  assign src_pend[irq_dispatch_pkg::SRC_EXT0]   = ext_line0_pending_i;
  assign src_pend[irq_dispatch_pkg::SRC_T0]     = timer0_overflow_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_EXT1]   = ext_line1_pending_i;
  assign src_pend[irq_dispatch_pkg::SRC_T1]     = timer1_overflow_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_UART]   = uart_rx_complete_i | uart_tx_complete_i;
  assign src_pend[irq_dispatch_pkg::SRC_T2]     = timer2_high_overflow_i
                                                  | timer2_low_overflow_i;
  assign src_pend[irq_dispatch_pkg::SRC_SPI0]   = serial_port_transfer_done_i
                                                  | write_collision_i
                                                  | mode_fault_i
                                                  | receive_overrun_i;
  assign src_pend[irq_dispatch_pkg::SRC_TWI]    = two_wire_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_RTC]    = rtc_alarm_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_ADCWIN] = adc_window_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_ADC]    = conversion_done_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_PCA]    = counter_array_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_CMP0]   = |comparator0_flags_i;
  assign src_pend[irq_dispatch_pkg::SRC_CMP1]   = |comparator1_flags_i;
  assign src_pend[irq_dispatch_pkg::SRC_T3]     = |timer3_flags_i;
  // warning pends while a supply is not good
  assign src_pend[irq_dispatch_pkg::SRC_SUPPLY] = ~supply_good_flag_i | ~battery_good_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_PMATCH] = port_match_i;
  assign src_pend[irq_dispatch_pkg::SRC_OSCF]   = osc_fail_flag_i;
  assign src_pend[irq_dispatch_pkg::SRC_SPI1]   = |serial_port1_flags_i;

  irq_arbiter #(
    .N (N),
    .W (W)
  ) u_arb (
    .pend_i       (src_pend),
    .en_i         (src_en),
    .pri_i        (src_pri),
    .global_i     (global_irq_gate),
    .insvc_low_i  (st_r.insvc_low),
    .insvc_high_i (st_r.insvc_high),
    .req_o        (arb_req),
    .idx_o        (arb_idx),
    .level_o      (arb_level),
    .hi_cand_o    (arb_hi)
  );

  assign take = cpu_ack_i & st_r.req;

  always_comb begin
    st_nxt     = st_r;
    st_nxt.clr = 4'h0;
    if (take) begin
      if (st_r.level) begin
        st_nxt.insvc_high = 1'b1;
      end else begin
        st_nxt.insvc_low = 1'b1;
      end
      if (st_r.idx < irq_dispatch_pkg::HW_CLR_N) begin
        st_nxt.clr[st_r.idx[1:0]] = 1'b1;
      end
    end else if (cpu_reti_i) begin
      if (st_r.insvc_high) begin
        st_nxt.insvc_high = 1'b0;
      end else begin
        st_nxt.insvc_low = 1'b0;
      end
    end
    st_nxt.req = arb_req & ~cpu_ack_i;
    if (arb_req) begin
      st_nxt.idx   = arb_idx;
      st_nxt.level = arb_level;
      // base plus 8 bytes per order step
      st_nxt.vec   = irq_dispatch_pkg::VEC_BASE + 16'({arb_idx, 3'b000});
    end
    if (srst_i) begin
      st_nxt     = '0;
      st_nxt.vec = irq_dispatch_pkg::RESET_VEC;
    end
  end

  always_ff @(posedge mclk_i) begin
    st_r <= st_nxt;
  end

  assign irq_req_o    = st_r.req;
  assign irq_vector_o = st_r.vec;
  assign irq_level_o  = st_r.level;
  assign hw_clear_o   = st_r.clr;
  assign in_service_o = {st_r.insvc_high, st_r.insvc_low};

  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (srst_i);

  AST_VECTOR_FROM_ORDER: assert property (
    irq_req_o |-> irq_vector_o == 16'h0003 + 16'({st_r.idx, 3'b000})
                  && (($past(src_pend) >> st_r.idx) & 19'h00001) != 19'h00000)
    else $error("vector does not match a pending source");

  AST_FIXED_ORDER: assert property (
    irq_req_o |-> ((irq_level_o ? $past(src_pend & src_en & src_pri)
                                : $past(src_pend & src_en & ~src_pri))
                   & ((19'h00001 << st_r.idx) - 19'h00001)) == 19'h00000)
    else $error("lower order source of same level skipped");

  AST_HW_CLEAR_FIRST_FOUR: assert property (
    (take && st_r.idx < 5'h04) |=> hw_clear_o == (4'h1 << $past(st_r.idx[1:0])))
    else $error("auto clear pulse missing or wrong");

  AST_NO_CLEAR_OTHERS: assert property (
    !(take && st_r.idx < 5'h04) |=> hw_clear_o == 4'h0)
    else $error("unexpected auto clear pulse");

  AST_GLOBAL_GATE_BLOCKS: assert property (
    !global_irq_gate |=> !irq_req_o)
    else $error("request while global gate closed");

  AST_RESET_VECTOR: assert property (disable iff (1'b0)
    srst_i |=> irq_vector_o == 16'h0000 && !irq_req_o && hw_clear_o == 4'h0)
    else $error("reset vector not presented");

  AST_HIGH_NOT_PREEMPTED: assert property (
    st_r.insvc_high |=> !irq_req_o)
    else $error("request raised during high level service");

  AST_LOW_PREEMPTED_BY_HIGH: assert property (
    (st_r.insvc_low && !st_r.insvc_high && arb_hi && !cpu_ack_i)
    |=> irq_req_o && irq_level_o)
    else $error("high request did not preempt low service");

  AST_PENDING_SERVED: assert property (
    (!st_r.insvc_low && !st_r.insvc_high && !cpu_ack_i && global_irq_gate
     && (src_pend & src_en) != 19'h00000) |=> irq_req_o)
    else $error("enabled pending source not requested");

  AST_REQUEST_AFTER_RETURN: assert property (
    (cpu_reti_i && !st_r.insvc_high && !cpu_ack_i && global_irq_gate && enable_mask[0]
     && ext_line0_pending_i)
    ##1 (!cpu_ack_i && global_irq_gate && enable_mask[0] && ext_line0_pending_i)
    |=> irq_req_o)
    else $error("pending flag after return not re-requested");

  AST_SUPPLY_VECTOR: assert property (
    (irq_req_o && st_r.idx == 5'h0F) |-> irq_vector_o == 16'h007B)
    else $error("supply warning vector wrong");

  AST_CONVERSION_VECTOR: assert property (
    (irq_req_o && irq_vector_o == 16'h0053) |-> $past(ext_en1[3] && conversion_done_flag_i))
    else $error("conversion done request without its enable");

endmodule : irq_enable_priority_dispatch
`default_nettype wire

// ===== testbench/irq_core_model.sv
`default_nettype none
module irq_core_model (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  // Dispatch side
  input  wire logic        irq_req_i,
  input  wire logic [15:0] irq_vector_i,
  input  wire logic [3:0]  hw_clear_i,
  output logic             cpu_ack_o,
  // Bench control
  input  wire logic        ack_en_i,
  input  wire logic [3:0]  ack_delay_i,
  input  wire logic [3:0]  flag_set_i,
  output logic [3:0]       flag_o,
  output logic [15:0]      taken_vec_o,
  output logic [7:0]       ack_count_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_r;
  // flags drop on clear pulse, a new set wins
  always @(posedge mclk_i) begin
    if (srst_i) begin
      flag_o <= 4'h0;
    end else begin
      flag_o <= (flag_o & ~hw_clear_i) | flag_set_i;
    end
  end
  // Core answers after a chosen number of request cycles
  always @(posedge mclk_i) begin
    if (srst_i) begin
      cpu_ack_o   <= 1'b0;
      wait_r      <= 4'h0;
      ack_count_o <= 8'h00;
    end else if (cpu_ack_o) begin
      cpu_ack_o <= 1'b0;
      if (irq_req_i) begin
        taken_vec_o <= irq_vector_i;
        ack_count_o <= ack_count_o + 8'h01;
      end
    end else if (ack_en_i && irq_req_i) begin
      if (wait_r >= ack_delay_i) begin
        cpu_ack_o <= 1'b1;
        wait_r    <= 4'h0;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end else begin
      wait_r <= 4'h0;
    end
  end
endmodule : irq_core_model
`default_nettype wire

// ===== testbench/irq_enable_priority_dispatch_bench.sv
`default_nettype none
module irq_enable_priority_dispatch_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] S_IDLE = 32'h0018_0000;
  localparam int SBIT [4:18] = '{0, 3, 7, 8, 9, 10, 11, 12, 13, 16, 17, 20, 21, 22, 26};
  logic mclk_i = 1'b0, srst_i = 1'b1, wr = 1'b0, bwr = 1'b0, bval = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, acks;
  logic [31:0] s = S_IDLE;
  logic ack_en = 1'b0, cpu_ack, cpu_reti = 1'b0, req, level, hit;
  logic [3:0] ack_dly = 4'h0, fset = 4'h0, hwc, flag;
  logic [15:0] vec, tvec;
  logic [1:0] insvc;
  int bad_count = 0, tests_run = 0;

  always #5 mclk_i = ~mclk_i;

  irq_enable_priority_dispatch uut (
    .mclk_i(mclk_i), .srst_i(srst_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_bit_wr_i(bwr), .sfr_bit_val_i(bval), .sfr_rd_i(rd),
    .sfr_rdata_o(rdata), .sfr_hit_o(hit),
    .ext_line0_pending_i(flag[0]), .timer0_overflow_flag_i(flag[1]),
    .ext_line1_pending_i(flag[2]), .timer1_overflow_flag_i(flag[3]),
    .uart_rx_complete_i(s[0]), .uart_tx_complete_i(s[1]),
    .timer2_high_overflow_i(s[2]), .timer2_low_overflow_i(s[3]),
    .serial_port_transfer_done_i(s[4]), .write_collision_i(s[5]), .mode_fault_i(s[6]),
    .receive_overrun_i(s[7]), .two_wire_flag_i(s[8]), .rtc_alarm_flag_i(s[9]),
    .adc_window_flag_i(s[10]), .conversion_done_flag_i(s[11]), .counter_array_flag_i(s[12]),
    .comparator0_flags_i(s[14:13]), .comparator1_flags_i(s[16:15]),
    .timer3_flags_i(s[18:17]), .supply_good_flag_i(s[19]), .battery_good_flag_i(s[20]),
    .port_match_i(s[21]), .osc_fail_flag_i(s[22]), .serial_port1_flags_i(s[26:23]),
    .cpu_ack_i(cpu_ack), .cpu_reti_i(cpu_reti), .irq_req_o(req), .irq_vector_o(vec),
    .irq_level_o(level), .hw_clear_o(hwc), .in_service_o(insvc)
  );

  irq_core_model core (
    .mclk_i(mclk_i), .srst_i(srst_i), .irq_req_i(req), .irq_vector_i(vec),
    .hw_clear_i(hwc), .cpu_ack_o(cpu_ack), .ack_en_i(ack_en), .ack_delay_i(ack_dly),
    .flag_set_i(fset), .flag_o(flag), .taken_vec_o(tvec), .ack_count_o(acks)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(negedge mclk_i);
  endtask : tick

  task automatic do_reset;
    srst_i = 1'b1;
    s      = S_IDLE;
    tick(3);
    srst_i = 1'b0;
  endtask : do_reset

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr  = a;
    wdata = d;
    wr    = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wr_reg

  task automatic wr_bit(input logic [7:0] a, input logic v);
    addr = a;
    bval = v;
    bwr  = 1'b1;
    tick(1);
    bwr = 1'b0;
    tick(1);
  endtask : wr_bit

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] d, input logic h);
    addr = a;
    rd   = 1'b1;
    tick(1);
    rd = 1'b0;
    check({8'h00, rdata}, {8'h00, d});
    check({15'h0, hit}, {15'h0, h});
    tick(1);
  endtask : rd_chk

  task automatic take_ack(input logic [3:0] dly);
    logic [7:0] n0;
    n0      = acks;
    ack_dly = dly;
    ack_en  = 1'b1;
    for (int k = 0; k < 20 && acks === n0; k++) tick(1);
    ack_en = 1'b0;
    check({8'h00, acks}, {8'h00, n0 + 8'h01});
  endtask : take_ack

  task automatic reti;
    cpu_reti = 1'b1;
    tick(1);
    cpu_reti = 1'b0;
  endtask : reti

  task automatic test_gate;
    do_reset;
    check(vec, 16'h0000);
    rd_chk(8'hA8, 8'h00, 1'b1);
    rd_chk(8'hB8, 8'h80, 1'b1);
    rd_chk(8'h10, 8'h00, 1'b0);
    wr_reg(8'hA8, 8'h7F);
    s    = S_IDLE ^ 32'h7F;
    fset = 4'hF;
    tick(1);
    fset = 4'h0;
    tick(4);
    check({15'h0, req}, 16'h0000);
    wr_bit(8'hAF, 1'b1);
    tick(1);
    check({15'h0, req}, 16'h0001);
    check(vec, 16'h0003);
    rd_chk(8'hA8, 8'hFF, 1'b1);
    wr_bit(8'hAF, 1'b0);
    tick(1);
    check({15'h0, req}, 16'h0000);
    $display("done: gate");
  endtask : test_gate

  task automatic test_vectors;
    logic [18:0] en;
    for (int i = 0; i < 19; i++) begin
      do_reset;
      en = 19'h1 << i;
      wr_reg(8'hA8, {1'b1, en[6:0]});
      wr_reg(8'hE6, en[14:7]);
      wr_reg(8'hE7, {4'h0, en[18:15]});
      if (i < 4) fset = 4'h1 << i;
      else s = S_IDLE ^ (32'h1 << SBIT[i]);
      tick(1);
      fset = 4'h0;
      tick(1);
      check({15'h0, req}, 16'h0001);
      check(vec, 16'h0003 + 16'(8 * i));
      take_ack(4'(i % 3));
      check(tvec, 16'h0003 + 16'(8 * i));
      check({12'h0, hwc}, (i < 4) ? 16'h1 << i : 16'h0);
      check({14'h0, insvc}, 16'h0001);
      reti;
      check({14'h0, insvc}, 16'h0000);
      tick(1);
      check({15'h0, req}, (i < 4) ? 16'h0 : 16'h1);
    end
    $display("done: vectors");
  endtask : test_vectors

  task automatic test_alt_flags;
    int bits [6] = '{1, 2, 4, 5, 6, 19};
    logic [15:0] vexp [6] = '{16'h0023, 16'h002B, 16'h0033, 16'h0033, 16'h0033, 16'h007B};
    do_reset;
    wr_reg(8'hA8, 8'hF0);
    wr_reg(8'hE7, 8'h01);
    for (int k = 0; k < 6; k++) begin
      s = S_IDLE ^ (32'h1 << bits[k]);
      tick(1);
      check(vec, vexp[k]);
      s = S_IDLE;
      tick(1);
      check({15'h0, req}, 16'h0000);
    end
    $display("done: alt_flags");
  endtask : test_alt_flags

  task automatic test_priority;
    do_reset;
    wr_reg(8'hA8, 8'h94);
    s    = S_IDLE | 32'h1;
    fset = 4'h4;
    tick(1);
    fset = 4'h0;
    tick(1);
    check(vec, 16'h0013);
    take_ack(4'h2);
    check({15'h0, req}, 16'h0000);
    wr_bit(8'hBC, 1'b1);
    tick(1);
    check({level, vec[14:0]}, 16'h8023);
    take_ack(4'h0);
    check({14'h0, insvc}, 16'h0003);
    s = S_IDLE;
    wr_bit(8'hBA, 1'b1);
    fset = 4'h4;
    tick(1);
    fset = 4'h0;
    tick(2);
    check({15'h0, req}, 16'h0000);
    reti;
    check({14'h0, insvc}, 16'h0001);
    tick(1);
    check({level, vec[14:0]}, 16'h8013);
    $display("done: priority");
  endtask : test_priority

  task automatic results;
    $display("checks=%0d mismatches=%0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : results

  initial begin
    repeat (20000) @(posedge mclk_i);
    bad_count++;
    results;
  end

  initial begin
    test_gate;
    test_vectors;
    test_alt_flags;
    test_priority;
    results;
  end
endmodule : irq_enable_priority_dispatch_bench
`default_nettype wire
